// file: logic/rcac_core.sv
`timescale 1ns/1ps
// What this block does
// - Mode low nibble picks one of eight sources
// - Mode bit 4 picks interrupt counter
// - Mode bits 7-5 pick reference base clock
// - Base codes 11x supply no clock
// - Run bit one starts, zero stops
// - Any counter overflow clears run bit
// - Reset clears run bit
// - Reference counter wraps to zero after 0x0fffff (20-bit range), counts base clock
// - Oscillator counter 24-bit, counts selected oscillation source (RC or external)
// - Per-counter flags; selected one raises request
// - Run zero: oscillators stopped, counters still
// - Run one: oscillate, oscillator counter counts, reference counter counts unless base code is 11x
// - Counter read: written value while running
// - Never both oscillator channels at once
module rcac_core
  import rcac_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              low_speed_clock,
  input  wire logic              low_speed_clock_x2,
  input  wire logic              high_speed_clock,
  input  wire logic              rc_oscillator_clock,
  input  wire logic              external_clock_input_zero,
  input  wire logic              external_clock_input_one,
  output rcac_osc_ctl_t          osc_ctl,
  output logic                   converter_interrupt_request,
  output logic                   irq
);

  // All checks share pclk and are off while reset is held
  default clocking cb_pclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic is_ch0(input logic [3:0] c);
    is_ch0 = (c >= OSC_CH0_LO) && (c <= OSC_CH0_HI);
  endfunction

  function automatic logic is_ch1(input logic [3:0] c);
    is_ch1 = (c >= OSC_CH1_LO) && (c <= OSC_CH1_HI);
  endfunction

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  rcac_mode_t            mode_r;
  logic                  run_r;
  logic [ST_W-1:0]       status_r;
  logic [ST_W-1:0]       mask_r;
  logic [CNT_W-1:0]      ref_cnt_r;
  logic [CNT_W-1:0]      osc_cnt_r;
  logic [CNT_W-1:0]      ref_wr_r;
  logic [CNT_W-1:0]      osc_wr_r;
  logic [2:0]            hs_div_r;
  logic [31:0]           prdata_r;
  logic [N_SRC-1:0]      sync1_r;
  logic [N_SRC-1:0]      sync2_r;
  logic [N_SRC-1:0]      sync3_r;
  logic                  conv_req_r;

  // Clock inputs are sampled, so each must stay below pclk/2
  wire  [N_SRC-1:0]      raw_src = {external_clock_input_one,
                                    external_clock_input_zero,
                                    rc_oscillator_clock,
                                    high_speed_clock,
                                    low_speed_clock_x2,
                                    low_speed_clock};
  wire  [N_SRC-1:0]      edge_w;

  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          sync3_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= raw_src[g];
          sync2_r[g] <= sync1_r[g];
          sync3_r[g] <= sync2_r[g];
        end
      end
      assign edge_w[g] = sync2_r[g] & ~sync3_r[g];
    end
  endgenerate

  // APB decode
  wire acc_w    = psel & penable;
  wire hit_ref  = (paddr == byte_addr(IDX_REF_CNT));
  wire hit_osc  = (paddr == byte_addr(IDX_OSC_CNT));
  wire hit_mode = (paddr == byte_addr(IDX_MODE));
  wire hit_ctrl = (paddr == byte_addr(IDX_CTRL));
  wire hit_st   = (paddr == byte_addr(IDX_STATUS));
  wire hit_mask = (paddr == byte_addr(IDX_MASK));
  wire hit_any  = hit_ref | hit_osc | hit_mode | hit_ctrl | hit_st
                  | hit_mask;
  wire wr_w     = acc_w & pwrite & hit_any;
  wire wr_ref   = wr_w & hit_ref;
  wire wr_osc   = wr_w & hit_osc;
  wire wr_mode  = wr_w & hit_mode;
  wire wr_ctrl  = wr_w & hit_ctrl;
  wire wr_st    = wr_w & hit_st;
  wire wr_mask  = wr_w & hit_mask;

  assign pready  = 1'b1;
  assign pslverr = acc_w & ~hit_any;

  // Base clock tick
  wire [2:0] hs_mask = (mode_r.base_sel == BASE_HS_D2) ? 3'h1 :
                       (mode_r.base_sel == BASE_HS_D4) ? 3'h3 :
                       (mode_r.base_sel == BASE_HS_D8) ? 3'h7 : 3'h0;
  wire hs_tick  = edge_w[SRC_HS] && ((hs_div_r & hs_mask) == 3'h0);
  wire base_off = (mode_r.base_sel[2:1] == BASE_OFF_TOP);
  wire base_tick =
      base_off                          ? 1'b0 :
      (mode_r.base_sel == BASE_LS)      ? edge_w[SRC_LS] :
      (mode_r.base_sel == BASE_LS_X2)   ? edge_w[SRC_LS_X2] :
      hs_tick;

  // Oscillation source tick
  wire osc_tick =
      (mode_r.osc_src == OSC_EXT0) ? edge_w[SRC_EXT0] :
      (mode_r.osc_src == OSC_EXT1) ? edge_w[SRC_EXT1] :
      (is_ch0(mode_r.osc_src) || is_ch1(mode_r.osc_src))
                                  ? edge_w[SRC_RC] : 1'b0;

  // Counters advance only on a sampled tick while run is set
  wire ref_step = run_r & base_tick & ~wr_ref;
  wire osc_step = run_r & osc_tick & ~wr_osc;
  wire ref_ovf  = ref_step & (ref_cnt_r >= REF_MAX);
  wire osc_ovf  = osc_step & (osc_cnt_r == OSC_MAX);
  wire ovf_any  = ref_ovf | osc_ovf;
  wire sel_ovf  = mode_r.irq_src ? osc_ovf : ref_ovf;

  wire [CNT_W-1:0] ref_cnt_nxt =
      wr_ref   ? pwdata[CNT_W-1:0] :
      ref_ovf  ? CNT_RESET :
      ref_step ? ref_cnt_r + 24'h00_0001 : ref_cnt_r;
  wire [CNT_W-1:0] osc_cnt_nxt =
      wr_osc   ? pwdata[CNT_W-1:0] :
      osc_ovf  ? CNT_RESET :
      osc_step ? osc_cnt_r + 24'h00_0001 : osc_cnt_r;

  // Hardware stop wins over a software write in the same cycle
  wire run_nxt = ovf_any ? 1'b0 :
                 wr_ctrl ? pwdata[CTRL_RUN_BIT] : run_r;

  wire [ST_W-1:0] ev_w = {sel_ovf, osc_ovf, ref_ovf};
  // Set wins over write-one-to-clear
  wire [ST_W-1:0] status_nxt =
      (status_r & ~(wr_st ? pwdata[ST_W-1:0] : {ST_W{1'b0}})) | ev_w;

  wire [CNT_W-1:0] ref_rd = run_r ? ref_wr_r : ref_cnt_r;
  wire [CNT_W-1:0] osc_rd = run_r ? osc_wr_r : osc_cnt_r;
  wire [31:0] rd_nxt =
      hit_ref  ? {8'h00, ref_rd} :
      hit_osc  ? {8'h00, osc_rd} :
      hit_mode ? {24'h00_0000, mode_r} :
      hit_ctrl ? {31'h0000_0000, run_r} :
      hit_st   ? {29'h0000_0000, status_r} :
      hit_mask ? {29'h0000_0000, mask_r} : 32'h0000_0000;
  wire rd_setup = psel & ~penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r     <= MODE_RESET;
      run_r      <= CTRL_RESET[CTRL_RUN_BIT];
      status_r   <= STAT_RESET;
      mask_r     <= STAT_RESET;
      ref_cnt_r  <= CNT_RESET;
      osc_cnt_r  <= CNT_RESET;
      ref_wr_r   <= CNT_RESET;
      osc_wr_r   <= CNT_RESET;
      hs_div_r   <= 3'h0;
      prdata_r   <= 32'h0000_0000;
      conv_req_r <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_r <= pwdata[7:0];
      end
      if (wr_mask) begin
        mask_r <= pwdata[ST_W-1:0];
      end
      if (wr_ref) begin
        ref_wr_r <= pwdata[CNT_W-1:0];
      end
      if (wr_osc) begin
        osc_wr_r <= pwdata[CNT_W-1:0];
      end
      if (rd_setup) begin
        prdata_r <= rd_nxt;
      end
      run_r      <= run_nxt;
      status_r   <= status_nxt;
      ref_cnt_r  <= ref_cnt_nxt;
      osc_cnt_r  <= osc_cnt_nxt;
      conv_req_r <= sel_ovf;
      hs_div_r   <= !run_r ? 3'h0 :
                    edge_w[SRC_HS] ? hs_div_r + 3'h1 : hs_div_r;
    end
  end

  // Only the selected channel runs, and only while converting
  assign osc_ctl.ch0_en  = run_r & is_ch0(mode_r.osc_src);
  assign osc_ctl.ch1_en  = run_r & is_ch1(mode_r.osc_src);
  assign osc_ctl.osc_src = mode_r.osc_src;
  assign prdata          = prdata_r;
  assign converter_interrupt_request = conv_req_r;
  assign irq             = |(status_r & mask_r);

  sequence s_rd_ref_run;
    psel && !penable && !pwrite && hit_ref && run_r;
  endsequence

  sequence s_holds_written;
    prdata[CNT_W-1:0] == $past(ref_wr_r);
  endsequence

  sequence s_start_ch0;
    wr_ctrl && pwdata[CTRL_RUN_BIT] && !ovf_any && is_ch0(mode_r.osc_src)
      && !wr_mode;
  endsequence

  run_stop_ovf_a: assert property (
    run_r && ovf_any |=> !run_r)
    else $error("run bit survived an overflow");

  idle_hold_a: assert property (
    !run_r && !wr_ref && !wr_osc |=> $stable(ref_cnt_r) && $stable(osc_cnt_r))
    else $error("counter moved while stopped");

  base_off_a: assert property (
    base_off && !wr_ref |=> $stable(ref_cnt_r))
    else $error("reference counter moved with no base clock");

  chan_excl_a: assert property (
    !(osc_ctl.ch0_en && osc_ctl.ch1_en))
    else $error("both oscillator channels enabled");

  irq_select_a: assert property (
    ref_ovf && !mode_r.irq_src |=> converter_interrupt_request
      && status_r[ST_CONV_REQ] && status_r[ST_REF_OVF])
    else $error("reference overflow did not raise request");

  osc_flag_a: assert property (
    osc_ovf |=> status_r[ST_OSC_OVF] && !run_r && osc_cnt_r == CNT_RESET)
    else $error("oscillator overflow not flagged");

  read_hold_a: assert property (
    s_rd_ref_run |=> s_holds_written)
    else $error("running read did not return written value");

  start_osc_a: assert property (
    s_start_ch0 |=> run_r && osc_ctl.ch0_en ##1 (osc_ctl.ch0_en || !run_r))
    else $error("channel zero did not start");

  ref_step_a: assert property (
    ref_step && !ref_ovf |=> ref_cnt_r == $past(ref_cnt_r) + 24'h00_0001)
    else $error("reference counter did not step by one");

  osc_step_a: assert property (
    osc_step && !osc_ovf |=> osc_cnt_r == $past(osc_cnt_r) + 24'h00_0001)
    else $error("oscillator counter did not step by one");

  ref_flag_a: assert property (
    ref_ovf |=> status_r[ST_REF_OVF] && !run_r && ref_cnt_r == CNT_RESET)
    else $error("reference overflow not flagged");

  irq_osc_a: assert property (
    osc_ovf && mode_r.irq_src |=> converter_interrupt_request
      && status_r[ST_CONV_REQ] && status_r[ST_OSC_OVF])
    else $error("oscillator overflow did not raise request");

  run_start_a: assert property (
    wr_ctrl && pwdata[CTRL_RUN_BIT] && !ovf_any |=> run_r)
    else $error("run bit did not set on write");

  run_clear_a: assert property (
    wr_ctrl && !pwdata[CTRL_RUN_BIT] |=> !run_r)
    else $error("run bit did not clear on write");

  osc_stop_a: assert property (
    !run_r |-> !osc_ctl.ch0_en && !osc_ctl.ch1_en)
    else $error("oscillator enabled while stopped");

  ext0_count_a: assert property (
    run_r && mode_r.osc_src == OSC_EXT0 && edge_w[SRC_EXT0] && !wr_osc
      |=> osc_cnt_r != $past(osc_cnt_r))
    else $error("external input zero edge not counted");

  hs_count_a: assert property (
    run_r && mode_r.base_sel == BASE_HS && edge_w[SRC_HS] && !wr_ref
      |=> ref_cnt_r != $past(ref_cnt_r))
    else $error("high-speed edge not counted");

endmodule

// file: logic/rcac_pkg.sv
package rcac_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_REF_CNT  = 16'hf300;
  localparam logic [15:0] IDX_OSC_CNT  = 16'hf304;
  localparam logic [15:0] IDX_MODE     = 16'hf308;
  localparam logic [15:0] IDX_CTRL     = 16'hf309;
  localparam logic [15:0] IDX_STATUS   = 16'hf30a;
  localparam logic [15:0] IDX_MASK     = 16'hf30b;
  localparam int          ADDR_W       = 20;

  // Reset values
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [2:0]  STAT_RESET   = 3'h0;
  localparam logic [23:0] CNT_RESET    = 24'h00_0000;

  // Field positions
  localparam int          CTRL_RUN_BIT = 0;
  localparam int          ST_REF_OVF   = 0;
  localparam int          ST_OSC_OVF   = 1;
  localparam int          ST_CONV_REQ  = 2;
  localparam int          ST_W         = 3;
  localparam int          CNT_W        = 24;

  // Counter limits
  localparam logic [23:0] REF_MAX      = 24'h0f_ffff;
  localparam logic [23:0] OSC_MAX      = 24'hff_ffff;

  // Oscillation source codes
  localparam logic [3:0]  OSC_EXT0     = 4'h0;
  localparam logic [3:0]  OSC_CH0_LO   = 4'h1;
  localparam logic [3:0]  OSC_CH0_HI   = 4'h4;
  localparam logic [3:0]  OSC_CH1_LO   = 4'h5;
  localparam logic [3:0]  OSC_CH1_HI   = 4'h6;
  localparam logic [3:0]  OSC_EXT1     = 4'h7;

  // Base clock codes
  localparam logic [2:0]  BASE_LS      = 3'h0;
  localparam logic [2:0]  BASE_LS_X2   = 3'h1;
  localparam logic [2:0]  BASE_HS      = 3'h2;
  localparam logic [2:0]  BASE_HS_D2   = 3'h3;
  localparam logic [2:0]  BASE_HS_D4   = 3'h4;
  localparam logic [2:0]  BASE_HS_D8   = 3'h5;
  localparam logic [1:0]  BASE_OFF_TOP = 2'h3;

  // Sampled clock inputs
  localparam int          SRC_LS       = 0;
  localparam int          SRC_LS_X2    = 1;
  localparam int          SRC_HS       = 2;
  localparam int          SRC_RC       = 3;
  localparam int          SRC_EXT0     = 4;
  localparam int          SRC_EXT1     = 5;
  localparam int          N_SRC        = 6;

  typedef struct packed {
    logic [2:0] base_sel;
    logic       irq_src;
    logic [3:0] osc_src;
  } rcac_mode_t;

  typedef struct packed {
    logic       ch0_en;
    logic       ch1_en;
    logic [3:0] osc_src;
  } rcac_osc_ctl_t;

endpackage

// file: verification/rcac_far_side.sv
`timescale 1ns/1ps
module rcac_far_side
  import rcac_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire rcac_osc_ctl_t osc_ctl,
  input  wire logic          dbl_en,
  input  wire logic          ext_en,
  output logic               low_speed_clock,
  output logic               low_speed_clock_x2,
  output logic               high_speed_clock,
  output logic               rc_oscillator_clock,
  output logic               external_clock_input_zero,
  output logic               external_clock_input_one
);
  logic [3:0] div_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // Every phase spans two or more pclk periods, so the sampler sees it
  assign low_speed_clock           = div_r[3];
  // Doubler output exists only once software has enabled it
  assign low_speed_clock_x2        = dbl_en & div_r[2];
  assign high_speed_clock          = div_r[1];
  // Sensor network stands still unless a channel is enabled
  assign rc_oscillator_clock       = (osc_ctl.ch0_en | osc_ctl.ch1_en)
                                     & div_r[2];
  assign external_clock_input_zero = ext_en & div_r[2];
  assign external_clock_input_one  = ext_en & ~div_r[2];
endmodule

// file: verification/test_rcac_core.sv
`timescale 1ns/1ps
module test_rcac_core
  import rcac_pkg::*;
;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              ls_clk;
  logic              ls2_clk;
  logic              hs_clk;
  logic              rc_clk;
  logic              ext0_clk;
  logic              ext1_clk;
  rcac_osc_ctl_t     osc_ctl;
  logic              conv_req;
  logic              irq;
  logic              dbl_en;
  logic              ext_en;
  logic [31:0]       rd;
  logic              last_err;
  logic [3:0]        src_v;
  int                miscompares;
  int                total_checks;
  int                req_cnt;

  rcac_core u_rcac_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_clock(ls_clk), .low_speed_clock_x2(ls2_clk),
    .high_speed_clock(hs_clk), .rc_oscillator_clock(rc_clk),
    .external_clock_input_zero(ext0_clk), .external_clock_input_one(ext1_clk),
    .osc_ctl(osc_ctl), .converter_interrupt_request(conv_req), .irq(irq));

  rcac_far_side u_rcac_far_side (.pclk(pclk), .presetn(presetn),
    .osc_ctl(osc_ctl), .dbl_en(dbl_en), .ext_en(ext_en),
    .low_speed_clock(ls_clk), .low_speed_clock_x2(ls2_clk),
    .high_speed_clock(hs_clk), .rc_oscillator_clock(rc_clk),
    .external_clock_input_zero(ext0_clk), .external_clock_input_one(ext1_clk));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Request is a one-cycle pulse, so count it rather than poll it
  always @(posedge pclk) begin
    if (!presetn) begin
      req_cnt <= 0;
    end else if (conv_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic wr, input logic [15:0] idx,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ADDR_W'({idx, 2'b00});
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [15:0] idx,
                       input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic wait_stop();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 100) begin
      xfer(1'b0, IDX_CTRL, 32'h0);
      n++;
    end
    if (rd[0] !== 1'b0) begin
      miscompares++;
      wrap_up();
    end
  endtask

  initial begin
    {psel, penable, pwrite, dbl_en, ext_en} = 5'h0;
    paddr = '0;
    pwdata = 32'h0;
    presetn = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdchk("mode rst", IDX_MODE, 32'(MODE_RESET));
    rdchk("ctrl rst", IDX_CTRL, 32'(CTRL_RESET));
    rdchk("status rst", IDX_STATUS, 32'(STAT_RESET));
    rdchk("mask rst", IDX_MASK, 32'h0);
    rdchk("ref rst", IDX_REF_CNT, 32'(CNT_RESET));
    xfer(1'b0, 16'hf30c, 32'h0);
    chk("bad addr data", rd, 32'h0);
    chk("bad addr err", 32'(last_err), 32'h1);
    // Codes 8-15 are never written
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, IDX_MODE, {24'h0, 3'h6, 1'b0, 4'(c)});
      xfer(1'b1, IDX_CTRL, 32'h1);
      @(negedge pclk);
      chk("ch0", 32'(osc_ctl.ch0_en), 32'(c inside {[1:4]}));
      chk("ch1", 32'(osc_ctl.ch1_en), 32'(c inside {[5:6]}));
      chk("osc src", 32'(osc_ctl.osc_src), 32'(c));
      rdchk("run on", IDX_CTRL, 32'h1);
      xfer(1'b1, IDX_CTRL, 32'h0);
      @(negedge pclk);
      chk("osc off", 32'({osc_ctl.ch0_en, osc_ctl.ch1_en}), 32'h0);
    end
    xfer(1'b1, IDX_MASK, 32'h7);
    for (int b = 0; b < 6; b++) begin
      dbl_en <= (b == 1);
      xfer(1'b1, IDX_MODE, {24'h0, 3'(b), 1'b0, OSC_EXT0});
      xfer(1'b1, IDX_REF_CNT, 32'h000f_fffe);
      xfer(1'b1, IDX_CTRL, 32'h1);
      rdchk("ref held", IDX_REF_CNT, 32'h000f_fffe);
      wait_stop();
      rdchk("ref wrap", IDX_REF_CNT, 32'h0);
      rdchk("st ref", IDX_STATUS, 32'h5);
      chk("irq ref", 32'(irq), 32'h1);
      chk("req ref", req_cnt, b + 1);
      xfer(1'b1, IDX_STATUS, 32'h7);
    end
    // External inputs handed to their pins before use
    ext_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      src_v = (k == 0) ? OSC_CH0_LO : (k == 1) ? OSC_CH1_HI :
              (k == 2) ? OSC_EXT0 : OSC_EXT1;
      xfer(1'b1, IDX_MODE, {24'h0, 3'h6 | 3'(k & 1), 1'b1, src_v});
      xfer(1'b1, IDX_REF_CNT, 32'h0000_0010);
      xfer(1'b1, IDX_OSC_CNT, 32'h00ff_fffe);
      xfer(1'b1, IDX_CTRL, 32'h1);
      rdchk("osc held", IDX_OSC_CNT, 32'h00ff_fffe);
      wait_stop();
      rdchk("osc wrap", IDX_OSC_CNT, 32'h0);
      rdchk("ref still", IDX_REF_CNT, 32'h0000_0010);
      rdchk("st osc", IDX_STATUS, 32'h6);
      chk("req osc", req_cnt, 7 + k);
      xfer(1'b1, IDX_MASK, 32'h0);
      @(negedge pclk);
      chk("irq masked", 32'(irq), 32'h0);
      xfer(1'b1, IDX_MASK, 32'h7);
      xfer(1'b1, IDX_STATUS, 32'h7);
    end
    rdchk("st clr", IDX_STATUS, 32'h0);
    chk("irq clr", 32'(irq), 32'h0);
    // Input one keeps toggling while stopped; nothing may be counted
    repeat (40) @(posedge pclk);
    rdchk("osc idle", IDX_OSC_CNT, 32'h0);
    wrap_up();
  end
endmodule
